// file: pkg/playback_pkg.sv
/*
  Shared constants and types for the playback command timing block: the
  command opcode map, the chaining window, the busy time and the carriers
  between the command decoder and the per-channel sequencers.
  Assumes a single 25 MHz clock domain.
*/
// Function
// - A loop-begin command takes effect only while the addressed channel is playing.
// - The speaker gain command sets the gain only while the class AB amplifier is selected.
// - With the class D amplifier selected the gain value is ignored and the gain is held at 0 dB.
// - In two-times command mode the I2C slave address is sent and accepted once per transfer.
package playback_pkg;

  localparam int NUM_CHAN = 4;
  localparam int CLK_HZ = 25_000_000;
  localparam int CHAIN_WINDOW_US = 10_000;
  localparam int CHAIN_WINDOW_CYC = CHAIN_WINDOW_US * (CLK_HZ / 1_000_000);
  localparam logic [3:0] BUSY_CYC = 4'h8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam logic [3:0] OP_PLAY = 4'h1;
  localparam logic [3:0] OP_START = 4'h2;
  localparam logic [3:0] OP_SILENCE = 4'h3;
  localparam logic [3:0] OP_LOOP_BEGIN = 4'h4;
  localparam logic [3:0] OP_LOOP_CANCEL = 4'h5;
  localparam logic [3:0] OP_STOP = 4'h6;
  localparam logic [3:0] OP_STATUS = 4'h7;
  localparam logic [3:0] OP_GAIN = 4'h8;
  localparam logic [3:0] OP_POWER_UP = 4'h9;

  localparam logic [3:0] GAIN_UNITY = 4'hf;
  localparam logic [3:0] GAIN_RESET = 4'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef struct packed {
    logic phrase;
    logic loop_begin;
    logic loop_cancel;
    logic stop;
  } chan_cmd_t;

  typedef struct packed {
    logic playing;
    logic looping;
    logic next_req;
    logic window_missed;
  } chan_stat_t;

  typedef enum {I_IDLE, I_ADDR, I_AACK, I_DATA, I_DACK, I_SKIP} i2c_state_t;
  typedef enum {CH_IDLE, CH_PLAY} chan_state_t;

endpackage

// file: src/chan_sequencer.sv
/*
  One playback channel: phrase queue of depth one, loop flag, next-command
  request and the chaining-window watchdog.
  Assumes phrase_done is a one-cycle pulse from the playback engine on clk.
*/
`timescale 1ns/1ps
module chan_sequencer
  import playback_pkg::*;
#(
  parameter int WINDOW_CYC = CHAIN_WINDOW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input chan_cmd_t cmd,
  input wire logic phrase_done,
  output chan_stat_t stat
);
  localparam int CW = $clog2(WINDOW_CYC + 1);
  localparam logic [CW-1:0] WIN_LOAD = CW'(WINDOW_CYC);
  localparam logic [CW-1:0] WIN_ONE = CW'(1);

  chan_state_t st_r, st_nxt;
  logic queued_r, queued_nxt, loop_r, loop_nxt, ncr_r, ncr_nxt;
  logic miss_r, miss_nxt;
  logic [CW-1:0] win_r, win_nxt;

  always_comb begin
    st_nxt = st_r;
    queued_nxt = queued_r;
    loop_nxt = loop_r;
    miss_nxt = miss_r;
    case (st_r)
      CH_IDLE: begin
        if (cmd.phrase) begin
          st_nxt = CH_PLAY;
          queued_nxt = 1'b0;
        end
      end
      CH_PLAY: begin
        if (cmd.stop) begin
          st_nxt = CH_IDLE;
          queued_nxt = 1'b0;
          loop_nxt = 1'b0;
        end else begin
          if (cmd.loop_begin) begin
            loop_nxt = 1'b1;
          end
          if (cmd.loop_cancel) begin
            loop_nxt = 1'b0;
          end
          if (phrase_done) begin
            if (queued_r || cmd.phrase) begin
              queued_nxt = 1'b0;
            end else if (!loop_r) begin
              st_nxt = CH_IDLE;
            end
          end else if (cmd.phrase) begin
            queued_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = CH_IDLE;
    endcase
    ncr_nxt = (st_nxt == CH_PLAY) && !queued_nxt;
    // The watchdog only reports a missed window; playback itself goes on.
    win_nxt = ncr_r ? ((win_r == '0) ? win_r : win_r - WIN_ONE) : WIN_LOAD;
    if (cmd.phrase) begin
      miss_nxt = 1'b0;
    end else if (ncr_r && win_r == WIN_ONE) begin
      miss_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= CH_IDLE;
      queued_r <= 1'b0;
      loop_r <= 1'b0;
      ncr_r <= 1'b0;
      miss_r <= 1'b0;
      win_r <= WIN_LOAD;
    end else begin
      st_r <= st_nxt;
      queued_r <= queued_nxt;
      loop_r <= loop_nxt;
      ncr_r <= ncr_nxt;
      miss_r <= miss_nxt;
      win_r <= win_nxt;
    end
  end

  assign stat = '{playing: st_r == CH_PLAY, looping: loop_r,
                  next_req: ncr_r, window_missed: miss_r};

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_loop_idle_ignored: assert property (
    (st_r == CH_IDLE && cmd.loop_begin) |=> !loop_r)
    else $error("Loop began on an idle channel.");

  a_ncr_drops_taken: assert property (
    (ncr_r && cmd.phrase && !cmd.stop && !phrase_done) |=> !ncr_r && queued_r)
    else $error("Request stayed high after a phrase was taken.");

endmodule // chan_sequencer

// file: src/playback_command_timing.sv
/*
  Command front end: I2C slave with address match and two-times byte mode,
  command decoder, busy output, speaker gain by amplifier class and four
  channel sequencers.
  Assumes scl, sda and the mode straps are asynchronous pins and that
  phrase_done comes from playback logic on clk.
*/
`timescale 1ns/1ps
module playback_command_timing
  import playback_pkg::*;
#(
  parameter int WINDOW_CYC = CHAIN_WINDOW_CYC,
  parameter logic [6:0] OWN_ADDR = 7'h2a // Arbitrary value.
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic twice_mode,
  input wire logic class_d_sel,
  input wire logic [NUM_CHAN-1:0] phrase_done,
  output logic cmd_busy_n,
  output logic [NUM_CHAN-1:0] next_cmd_request,
  output logic [NUM_CHAN-1:0] playing,
  output logic [NUM_CHAN-1:0] window_missed,
  output logic [3:0] speaker_gain,
  output logic [7:0] status_word,
  output logic powered_up
);
  if (NUM_CHAN != 4) begin : g_chk
    $error("The channel mask and status layout need four channels.");
  end
  if (WINDOW_CYC < 2) begin : g_chk_win
    $error("WINDOW_CYC must be at least 2.");
  end

  logic rs1_r, rst_n;
  logic [3:0] sync1_r, sync2_r;
  logic scl_d_r, sda_d_r;

  // Reset is released through two flops so all state leaves reset together.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Straps start low so that no class D gain is forced just after reset.
      sync1_r <= 4'hc;
      sync2_r <= 4'hc;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= {scl_in, sda_in, twice_mode, class_d_sel};
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[3];
      sda_d_r <= sync2_r[2];
    end
  end

  logic scl_s, sda_s, twice_s, class_d_s;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign {scl_s, sda_s, twice_s, class_d_s} = sync2_r;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && !sda_s && sda_d_r;
  assign stop_c = scl_s && scl_d_r && sda_s && !sda_d_r;

  i2c_state_t ist_r, ist_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, first_r, first_nxt;
  logic oe_r, oe_nxt, have_r, have_nxt;
  logic addr_match, byte_stb, cmd_issue;

  assign addr_match = (sh_r[7:1] == OWN_ADDR) && !sh_r[0];

  always_comb begin
    ist_nxt = ist_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    oe_nxt = oe_r;
    first_nxt = first_r;
    have_nxt = have_r;
    byte_stb = 1'b0;
    cmd_issue = 1'b0;
    if (start_c) begin
      ist_nxt = I_ADDR;
      cnt_nxt = '0;
      oe_nxt = 1'b0;
      have_nxt = 1'b0;
    end else if (stop_c) begin
      ist_nxt = I_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (ist_r)
        I_IDLE, I_SKIP: begin
          oe_nxt = 1'b0;
        end
        I_ADDR, I_DATA: begin
          if (scl_rise && cnt_r != BITS_PER_BYTE) begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
            cnt_nxt = '0;
            if (ist_r == I_DATA) begin
              oe_nxt = 1'b1;
              ist_nxt = I_DACK;
              byte_stb = 1'b1;
            end else if (addr_match) begin
              oe_nxt = 1'b1;
              ist_nxt = I_AACK;
            end else begin
              ist_nxt = I_SKIP;
            end
          end
        end
        I_AACK, I_DACK: begin
          // Later bytes are data only, so the address is taken once.
          if (scl_fall) begin
            oe_nxt = 1'b0;
            ist_nxt = I_DATA;
          end
        end
        default: ist_nxt = I_IDLE;
      endcase
    end
    if (byte_stb) begin
      if (!twice_s) begin
        cmd_issue = 1'b1;
      end else if (!have_r) begin
        first_nxt = sh_r;
        have_nxt = 1'b1;
      end else begin
        have_nxt = 1'b0;
        cmd_issue = (first_r == sh_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= I_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      oe_r <= 1'b0;
      first_r <= '0;
      have_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      oe_r <= oe_nxt;
      first_r <= first_nxt;
      have_r <= have_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;

  logic [3:0] op, arg, busy_r, busy_nxt, gain_r, gain_nxt;
  logic [7:0] status_r, status_nxt;
  logic go, known, busy_n_r, pwr_r, pwr_nxt;
  chan_cmd_t ccmd [NUM_CHAN];
  chan_stat_t cstat [NUM_CHAN];
  logic [NUM_CHAN-1:0] looping;

  assign op = sh_r[7:4];
  assign arg = sh_r[3:0];
  assign known = (op >= OP_PLAY) && (op <= OP_POWER_UP);
  // A byte during busy or outside the command set is dropped silently.
  assign go = cmd_issue && known && busy_r == '0;

  always_comb begin
    busy_nxt = go ? BUSY_CYC : ((busy_r == '0) ? busy_r : busy_r - 4'h1);
    gain_nxt = gain_r;
    if (class_d_s) begin
      gain_nxt = GAIN_UNITY;
    end else if (go && op == OP_GAIN) begin
      gain_nxt = arg;
    end
    status_nxt = (go && op == OP_STATUS) ? {looping, playing} : status_r;
    pwr_nxt = pwr_r || (go && op == OP_POWER_UP);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= '0;
      busy_n_r <= 1'b1;
      gain_r <= GAIN_RESET;
      status_r <= STATUS_RESET;
      pwr_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      busy_n_r <= (busy_nxt == '0);
      gain_r <= gain_nxt;
      status_r <= status_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  assign cmd_busy_n = busy_n_r;
  assign speaker_gain = gain_r;
  assign status_word = status_r;
  assign powered_up = pwr_r;

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    // A zero channel mask selects nothing, so such a command is ignored.
    assign ccmd[i] = '{
      phrase: go && arg[i] &&
              (op == OP_PLAY || op == OP_START || op == OP_SILENCE),
      loop_begin: go && arg[i] && op == OP_LOOP_BEGIN,
      loop_cancel: go && arg[i] && op == OP_LOOP_CANCEL,
      stop: go && arg[i] && op == OP_STOP};
    chan_sequencer #(.WINDOW_CYC(WINDOW_CYC)) u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .cmd(ccmd[i]),
      .phrase_done(phrase_done[i]),
      .stat(cstat[i])
    );
    assign next_cmd_request[i] = cstat[i].next_req;
    assign playing[i] = cstat[i].playing;
    assign looping[i] = cstat[i].looping;
    assign window_missed[i] = cstat[i].window_missed;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_done;
    ist_r == I_ADDR && scl_fall && cnt_r == BITS_PER_BYTE;
  endsequence

  a_ack_own_addr: assert property (
    (s_addr_done and addr_match) |=> sda_oe && ist_r == I_AACK)
    else $error("Own address was not acknowledged.");

  a_nack_foreign: assert property (
    (s_addr_done and !addr_match && !start_c && !stop_c) |=>
      !sda_oe [*2])
    else $error("Foreign address was acknowledged.");

  a_addr_once: assert property (
    (ist_r == I_DACK || ist_r == I_DATA) && !start_c |=> ist_r != I_AACK)
    else $error("Address phase repeated inside a transfer.");

  a_twice_first: assert property (
    (twice_s && byte_stb && !have_r) |-> !cmd_issue ##1 have_r)
    else $error("First copy of a doubled byte was executed.");

  a_gain_class_d: assert property (
    class_d_s |=> speaker_gain == GAIN_UNITY)
    else $error("Gain not fixed with class D amplifier.");

  a_gain_class_ab: assert property (
    (go && op == OP_GAIN && !class_d_s) |=> speaker_gain == $past(arg))
    else $error("Gain command not applied with class AB amplifier.");

endmodule // playback_command_timing

// file: verif/i2c_host_model.sv
/*
  Host model: an I2C master that sends command bytes to the block.
  Assumes SDA is resolved by the bench with a pull-up.
*/
`timescale 1ns/1ps
module i2c_host_model
  import playback_pkg::*;
#(
  parameter int PHASE = 6
) (
  input wire logic clk,
  input wire logic sda_line,
  input wire logic cmd_busy_n,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // A transfer starts once busy reads high, or after at most 100 clocks of waiting.
  task automatic start_cond();
    int i;
    i = 0;
    while (cmd_busy_n !== 1'b1 && i < 100) begin
      tick(1);
      i++;
    end
    sda_drv = 1'b0;
    tick(PHASE);
    scl = 1'b0;
    tick(PHASE);
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    tick(PHASE);
    scl = 1'b1;
    tick(PHASE);
    sda_drv = 1'b1;
    tick(PHASE);
  endtask

  // SDA moves two clocks after SCL falls, so no false start is seen.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_drv = (i > 0) ? b[i-1] : 1'b1;
      tick(PHASE);
      scl = 1'b1;
      tick(PHASE);
      ack = ~sda_line;
      scl = 1'b0;
      tick(2);
    end
  endtask
endmodule // i2c_host_model

// file: verif/test_playback_command_timing.sv
/*
  Self-checking bench for the playback command block, driving it through
  the host model. Assumes the design's opcode map and busy length.
*/
`timescale 1ns/1ps
module test_playback_command_timing;
  import playback_pkg::*;
  localparam int WIN = 20;
  localparam logic [6:0] ADDR = 7'h2a; // Arbitrary value.
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic twice_mode = 1'b0;
  logic class_d_sel = 1'b0;
  logic [NUM_CHAN-1:0] phrase_done = '0;
  logic scl, sda_drv, sda_out, sda_oe, cmd_busy_n, powered_up;
  logic [NUM_CHAN-1:0] next_cmd_request, playing, window_missed;
  logic [3:0] speaker_gain;
  logic [7:0] status_word;
  wire logic sda_line;
  int seed = 32'h1ae5;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int busy_seen = 0;

  assign sda_line = sda_drv & (~sda_oe | sda_out);
  always #20 clk = ~clk;

  playback_command_timing #(.WINDOW_CYC(WIN), .OWN_ADDR(ADDR))
    u_playback_command_timing (.clk(clk), .reset_n(reset_n),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .twice_mode(twice_mode), .class_d_sel(class_d_sel),
    .phrase_done(phrase_done), .cmd_busy_n(cmd_busy_n),
    .next_cmd_request(next_cmd_request), .playing(playing),
    .window_missed(window_missed), .speaker_gain(speaker_gain),
    .status_word(status_word), .powered_up(powered_up));

  i2c_host_model u_i2c_host_model (.clk(clk), .sda_line(sda_line),
    .cmd_busy_n(cmd_busy_n), .scl(scl), .sda_drv(sda_drv));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Busy falls while the command byte is still being acknowledged.
  always @(negedge clk) begin
    if (cmd_busy_n === 1'b0) begin
      busy_seen++;
    end
  end

  // A hung handshake ends the run with a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [3:0] exp_gain(logic cls_d, logic [3:0] g);
    return cls_d ? GAIN_UNITY : g;
  endfunction

  // Only opcodes of the defined set are sent.
  task automatic send(input logic [7:0] b0, input logic [7:0] b1,
                      input logic exec);
    logic ack;
    busy_seen = 0;
    u_i2c_host_model.start_cond();
    // The address goes out once, also in two-times mode.
    u_i2c_host_model.put_byte({ADDR, 1'b0}, ack);
    check("address ack", {7'h0, ack}, 8'h01);
    u_i2c_host_model.put_byte(b0, ack);
    if (twice_mode) begin
      u_i2c_host_model.put_byte(b1, ack);
    end
    u_i2c_host_model.stop_cond();
    check("busy cycles", 8'(busy_seen), exec ? {4'h0, BUSY_CYC} : 8'h00);
  endtask

  task automatic status(input logic [7:0] exp);
    send({OP_STATUS, 4'hf}, {OP_STATUS, 4'hf}, 1'b1);
    check("status", status_word, exp);
  endtask

  initial begin
    logic ack;
    logic [3:0] g;
    repeat (4) @(negedge clk);
    check("reset busy", {7'h0, cmd_busy_n}, 8'h01);
    check("reset oe", {7'h0, sda_oe}, 8'h00);
    check("reset chans", {next_cmd_request, playing}, 8'h00);
    check("reset gain", {status_word[3:0], speaker_gain}, 8'h00);
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    check("idle gain", {status_word[3:0], speaker_gain}, 8'h00);
    check("idle busy", {7'h0, cmd_busy_n}, 8'h01);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      u_i2c_host_model.start_cond();
      u_i2c_host_model.put_byte(i ? {ADDR, 1'b1} : {ADDR ^ 7'h01, 1'b0},
                                ack);
      check("foreign ack", {7'h0, ack}, 8'h00);
      u_i2c_host_model.stop_cond();
    end
    $display("test address done");
    send({OP_LOOP_BEGIN, 4'h1}, 8'h00, 1'b1);
    status(8'h00);
    send({OP_PLAY, 4'h1}, 8'h00, 1'b1);
    check("play ch0", {next_cmd_request, playing}, 8'h11);
    send({OP_LOOP_BEGIN, 4'h1}, 8'h00, 1'b1);
    status(8'h11);
    check("missed", {4'h0, window_missed}, 8'h01);
    send({OP_SILENCE, 4'h1}, 8'h00, 1'b1);
    check("queued", {next_cmd_request, window_missed}, 8'h00);
    phrase_done = 4'h1;
    @(negedge clk);
    phrase_done = 4'h0;
    repeat (3) @(negedge clk);
    check("requeue", {next_cmd_request, playing}, 8'h11);
    send({OP_STOP, 4'h1}, 8'h00, 1'b1);
    // Playback is confirmed finished before the next phrase.
    status(8'h00);
    send({OP_START, 4'ha}, 8'h00, 1'b1);
    check("start mask", {next_cmd_request, playing}, 8'haa);
    send({OP_LOOP_CANCEL, 4'ha}, 8'h00, 1'b1);
    send({OP_STOP, 4'ha}, 8'h00, 1'b1);
    check("stopped", {4'h0, playing}, 8'h00);
    send({OP_POWER_UP, 4'h1}, 8'h00, 1'b1);
    check("power up", {7'h0, powered_up}, 8'h01);
    $display("test channel done");
    for (int k = 0; k < 6; k++) begin
      class_d_sel = k[0];
      g = 4'($random(seed));
      if (g == 4'h0) begin
        g = 4'h1;
      end
      repeat (6) @(negedge clk);
      send({OP_GAIN, g}, 8'h00, 1'b1);
      check("gain", {4'h0, speaker_gain}, {4'h0, exp_gain(k[0], g)});
    end
    $display("test gain done");
    twice_mode = 1'b1;
    class_d_sel = 1'b0;
    repeat (6) @(negedge clk);
    g = 4'($random(seed));
    g[0] = 1'b1;
    send({OP_GAIN, g}, {OP_GAIN, g}, 1'b1);
    check("pair gain", {4'h0, speaker_gain}, {4'h0, g});
    send({OP_GAIN, g ^ 4'h2}, {OP_GAIN, g ^ 4'h4}, 1'b0);
    check("odd pair", {4'h0, speaker_gain}, {4'h0, g});
    $display("test twice done");
    summarize();
  end
endmodule // test_playback_command_timing
